// ---- bdra_top.sv ----
// bdra_top: refresh timer, refresh request machine, address decoder
// and ras/cas arbiter for a burst-capable dram array.
// assumes cpu inputs are asynchronous and the strobe is pre-delayed.
// Function
// - burst is four 32-bit long words
// - burst: ras+cas first, then cas only
// - all state on one fast clock standing in for the inverted processor clock
// - eight-bit free-running refresh counter
// - refresh request once per msb high phase
// - drop request once refresh cycle starts
// - wait for msb low before idle
// - access request on range match with strobe
// - arbitrate only in idle, refresh first
// - pending refresh enters cas-before-ras branch
// - access without refresh enters access branch
// - ras, then column select, then cas
// - refresh and reads assert all strobes
// - eleven-bit multiplexed dram address
`timescale 1ns/10ps
module bdra_top (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire bdra_pkg::bdra_cpu_s cpu_in,
  output bdra_pkg::bdra_dram_s dram_out,
  output logic refresh_request_out,
  output logic memory_access_request_out,
  output logic cpu_ok_out,
  output logic timer_msb_out
);
  import bdra_pkg::*;

  // -------------------------------------------------------------------
  // input synchronisers
  // -------------------------------------------------------------------
  // strobe arrives delayed clear of clock skew by the system
  bdra_cpu_s sync1_q;
  bdra_cpu_s cpu_q;
  always_ff @(posedge clk_in) begin
    sync1_q <= cpu_in;
    cpu_q <= sync1_q;
  end

  // -------------------------------------------------------------------
  // refresh timer
  // -------------------------------------------------------------------
  // one fast clock stands in for the inverted processor clock
  logic [2:0] pre_q;
  logic tick;
  logic [REF_CNT_W-1:0] ref_cnt_q;
  assign tick = (pre_q == PRE_LAST);
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      pre_q <= PRE_RST;
    end else if (tick) begin
      pre_q <= PRE_RST;
    end else begin
      pre_q <= pre_q + 3'h1;
    end
  end
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      ref_cnt_q <= REF_CNT_RST;
    end else if (tick) begin
      ref_cnt_q <= ref_cnt_q + 8'h01;
    end
  end
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      timer_msb_out <= 1'b0;
    end else begin
      timer_msb_out <= ref_cnt_q[REF_MSB];
    end
  end

  // -------------------------------------------------------------------
  // refresh request machine
  // -------------------------------------------------------------------
  bdra_req_e req_q;
  bdra_rc_e rc_q;
  logic ref_started;
  logic msb;
  assign msb = ref_cnt_q[REF_MSB];
  assign ref_started = (rc_q == RC_REF_CAS);
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      req_q <= REQ_IDLE;
    end else begin
      unique case (req_q)
        REQ_IDLE: begin
          if (msb) begin
            req_q <= REQ_ASSERT;
          end
        end
        REQ_ASSERT: begin
          if (ref_started) begin
            req_q <= REQ_WAIT_END;
          end
        end
        REQ_WAIT_END: begin
          if (!msb) begin
            req_q <= REQ_IDLE;
          end
        end
        default: begin
          req_q <= REQ_IDLE;
        end
      endcase
    end
  end
  logic ref_req;
  assign ref_req = (req_q == REQ_ASSERT) && !ref_started;
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      refresh_request_out <= 1'b0;
    end else begin
      refresh_request_out <= ref_req;
    end
  end

  // -------------------------------------------------------------------
  // address decoder
  // -------------------------------------------------------------------
  logic mem_req;
  assign mem_req = cpu_q.addr_strobe && (cpu_q.addr[DEC_HI:DEC_LO] == DEC_MATCH);
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      memory_access_request_out <= 1'b0;
    end else begin
      memory_access_request_out <= mem_req;
    end
  end

  // -------------------------------------------------------------------
  // ras/cas arbiter
  // -------------------------------------------------------------------
  logic [1:0] beat_q;
  logic burst_q;
  // marks that pre follows a cpu access rather than a refresh
  logic acc_q;
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      rc_q <= RC_IDLE;
      beat_q <= 2'h0;
      burst_q <= 1'b0;
      acc_q <= 1'b0;
    end else begin
      unique case (rc_q)
        RC_IDLE: begin
          beat_q <= 2'h0;
          acc_q <= 1'b0;
          if (ref_req) begin
            rc_q <= RC_REF_CAS;
          end else if (mem_req) begin
            rc_q <= RC_ROW;
            burst_q <= cpu_q.burst;
            acc_q <= 1'b1;
          end
        end
        RC_REF_CAS: rc_q <= RC_REF_RAS;
        RC_REF_RAS: rc_q <= RC_PRE;
        RC_ROW: rc_q <= RC_MUX;
        RC_MUX: rc_q <= RC_CAS;
        RC_CAS: begin
          // row stays open while the remaining long words are fetched
          if (burst_q && cpu_q.addr_strobe && beat_q != BEAT_LAST) begin
            beat_q <= beat_q + 2'h1;
            rc_q <= RC_MUX;
          end else begin
            rc_q <= RC_PRE;
          end
        end
        RC_PRE: begin
          // hold off until the strobe drops so one access is served once
          // a refresh must not wait on the strobe, or a pending access would stall
          if (!cpu_q.addr_strobe || !acc_q) begin
            rc_q <= RC_IDLE;
          end
          burst_q <= 1'b0;
        end
        default: rc_q <= RC_IDLE;
      endcase
    end
  end

  // -------------------------------------------------------------------
  // dram pin drive
  // -------------------------------------------------------------------
  bdra_dram_s dram_d;
  always_comb begin
    dram_d.ras = (rc_q == RC_REF_RAS) || (rc_q == RC_ROW) || (rc_q == RC_MUX)
               || (rc_q == RC_CAS);
    dram_d.cas = CAS_NONE;
    if (rc_q == RC_REF_CAS || rc_q == RC_REF_RAS) begin
      dram_d.cas = CAS_ALL;
    end else if (rc_q == RC_CAS) begin
      dram_d.cas = cpu_q.read ? CAS_ALL : cpu_q.lanes;
    end
    dram_d.column_address_select = (rc_q == RC_MUX) || (rc_q == RC_CAS);
    if (dram_d.column_address_select) begin
      dram_d.addr = {cpu_q.addr[COL_LO+DADDR_W-1:COL_LO+2],
                     2'(cpu_q.addr[COL_LO+1:COL_LO] + beat_q)};
    end else begin
      dram_d.addr = cpu_q.addr[ROW_LO+DADDR_W-1:ROW_LO];
    end
  end
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      dram_out <= '0;
      cpu_ok_out <= 1'b0;
    end else begin
      dram_out <= dram_d;
      cpu_ok_out <= (rc_q == RC_CAS);
    end
  end

  // -------------------------------------------------------------------
  // checks
  // -------------------------------------------------------------------
  sequence s_ref_cbr;
    rc_q == RC_REF_CAS ##1 rc_q == RC_REF_RAS;
  endsequence
  sequence s_row_col;
    rc_q == RC_ROW ##1 rc_q == RC_MUX ##1 rc_q == RC_CAS;
  endsequence
  property p_ref_prio;
    @(posedge clk_in) disable iff (!rstn_in)
      (rc_q == RC_IDLE && ref_req) |=> s_ref_cbr;
  endproperty
  a_ref_prio: assert property (p_ref_prio) else $error("refresh not taken first");
  property p_access;
    @(posedge clk_in) disable iff (!rstn_in)
      (rc_q == RC_IDLE && !ref_req && mem_req) |=> s_row_col;
  endproperty
  a_access: assert property (p_access) else $error("access branch order wrong");
  property p_req_drop;
    @(posedge clk_in) disable iff (!rstn_in)
      ref_started |=> req_q == REQ_WAIT_END;
  endproperty
  a_req_drop: assert property (p_req_drop) else $error("refresh request held");
  property p_wait_end;
    @(posedge clk_in) disable iff (!rstn_in)
      (req_q == REQ_WAIT_END && msb) |=> req_q == REQ_WAIT_END;
  endproperty
  a_wait_end: assert property (p_wait_end) else $error("left wait early");
  property p_once;
    @(posedge clk_in) disable iff (!rstn_in)
      (req_q == REQ_IDLE && msb) |=> req_q == REQ_ASSERT;
  endproperty
  a_once: assert property (p_once) else $error("request not raised");
  property p_decode;
    @(posedge clk_in) disable iff (!rstn_in)
      memory_access_request_out |-> $past(cpu_q.addr_strobe);
  endproperty
  a_decode: assert property (p_decode) else $error("access request without strobe");
  property p_cbr_pins;
    @(posedge clk_in) disable iff (!rstn_in)
      rc_q == RC_REF_RAS |=> dram_out.ras && dram_out.cas == CAS_ALL;
  endproperty
  a_cbr_pins: assert property (p_cbr_pins) else $error("refresh strobes wrong");
  property p_counter;
    @(posedge clk_in) disable iff (!rstn_in)
      tick |=> ref_cnt_q == $past(ref_cnt_q) + 8'h01;
  endproperty
  a_counter: assert property (p_counter) else $error("counter not stepping");
  property p_beats;
    @(posedge clk_in) disable iff (!rstn_in)
      (rc_q == RC_CAS && beat_q == BEAT_LAST) |=> rc_q == RC_PRE;
  endproperty
  a_beats: assert property (p_beats) else $error("burst past four beats");
  property p_ref_exit;
    @(posedge clk_in) disable iff (!rstn_in)
      (rc_q == RC_PRE && !acc_q) |=> rc_q == RC_IDLE;
  endproperty
  a_ref_exit: assert property (p_ref_exit) else $error("refresh did not return to idle");
  property p_pre_hold;
    @(posedge clk_in) disable iff (!rstn_in)
      (rc_q == RC_PRE && acc_q && cpu_q.addr_strobe) |=> rc_q == RC_PRE;
  endproperty
  a_pre_hold: assert property (p_pre_hold) else $error("access served twice");
  property p_read_cas;
    @(posedge clk_in) disable iff (!rstn_in)
      (rc_q == RC_CAS && cpu_q.read) |=> dram_out.cas == CAS_ALL;
  endproperty
  a_read_cas: assert property (p_read_cas) else $error("read cas lanes wrong");
  property p_row_addr;
    @(posedge clk_in) disable iff (!rstn_in)
      rc_q == RC_ROW |=> dram_out.addr == $past(cpu_q.addr[ROW_LO+DADDR_W-1:ROW_LO]);
  endproperty
  a_row_addr: assert property (p_row_addr) else $error("row address wrong");
  property p_ras_open;
    @(posedge clk_in) disable iff (!rstn_in)
      (rc_q == RC_MUX || rc_q == RC_CAS) |=> dram_out.ras;
  endproperty
  a_ras_open: assert property (p_ras_open) else $error("row closed inside access");
  property p_ok_beat;
    @(posedge clk_in) disable iff (!rstn_in)
      rc_q == RC_CAS |=> cpu_ok_out;
  endproperty
  a_ok_beat: assert property (p_ok_beat) else $error("beat not signalled");
  property p_msb_out;
    @(posedge clk_in) disable iff (!rstn_in)
      1'b1 |=> timer_msb_out == $past(msb);
  endproperty
  a_msb_out: assert property (p_msb_out) else $error("timer msb output wrong");

endmodule : bdra_top

// ---- bdra_pkg.sv ----
// bdra_pkg: constants, states and carrier structs for the dram front end
// assumes a single 200 MHz clock domain; no software registers
package bdra_pkg;

  // -------------------------------------------------------------------
  // counter and timing
  // -------------------------------------------------------------------
  localparam int REF_CNT_W = 8;
  localparam int REF_MSB = 7;
  localparam logic [7:0] REF_CNT_RST = 8'h00;
  localparam int CLK_MHZ = 200;
  localparam int PROC_CLK_MHZ = 25;
  // prescale so the counter steps at the processor clock rate
  localparam int PRE_DIV = CLK_MHZ / PROC_CLK_MHZ;
  localparam logic [2:0] PRE_LAST = 3'(PRE_DIV - 1);
  localparam logic [2:0] PRE_RST = 3'h0;

  // -------------------------------------------------------------------
  // address decode and dram geometry
  // -------------------------------------------------------------------
  localparam int ADDR_W = 32;
  localparam int DEC_HI = 27;
  localparam int DEC_LO = 24;
  localparam logic [3:0] DEC_MATCH = 4'h1;
  localparam int DADDR_W = 11;
  localparam int ROW_LO = 13;
  localparam int COL_LO = 2;
  localparam int BURST_BEATS = 4;
  localparam logic [1:0] BEAT_LAST = 2'(BURST_BEATS - 1);
  localparam int CAS_W = 4;
  localparam logic [3:0] CAS_ALL = 4'hf;
  localparam logic [3:0] CAS_NONE = 4'h0;

  // -------------------------------------------------------------------
  // states
  // -------------------------------------------------------------------
  typedef enum logic [1:0] {
    REQ_IDLE = 2'b00,
    REQ_ASSERT = 2'b01,
    REQ_WAIT_END = 2'b10
  } bdra_req_e;

  typedef enum logic [2:0] {
    RC_IDLE = 3'b000,
    RC_REF_CAS = 3'b001,
    RC_REF_RAS = 3'b010,
    RC_ROW = 3'b011,
    RC_MUX = 3'b100,
    RC_CAS = 3'b101,
    RC_PRE = 3'b110
  } bdra_rc_e;

  // -------------------------------------------------------------------
  // carriers
  // -------------------------------------------------------------------
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic addr_strobe;
    logic read;
    logic [CAS_W-1:0] lanes;
    logic burst;
  } bdra_cpu_s;

  typedef struct packed {
    logic ras;
    logic [CAS_W-1:0] cas;
    logic column_address_select;
    logic [DADDR_W-1:0] addr;
  } bdra_dram_s;

endpackage : bdra_pkg

// ---- bdra_cpu_model.sv ----
// bdra_cpu_model: behavioural processor bus master plus dram observer
// assumes the bench drives go_in at the falling edge; one clock domain
`timescale 1ns/10ps
module bdra_cpu_model (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic go_in,
  input wire logic [31:0] addr_in,
  input wire logic read_in,
  input wire logic burst_in,
  input wire logic ok_in,
  input wire bdra_pkg::bdra_dram_s dram_in,
  output bdra_pkg::bdra_cpu_s cpu_out,
  output logic [7:0] beats_out,
  output logic [7:0] ras_rises_out,
  output logic [7:0] cbr_out
);
  import bdra_pkg::*;
  logic ras_prev;
  logic [7:0] need;
  assign need = burst_in ? 8'h04 : 8'h01;
  initial begin
    cpu_out = '0;
    beats_out = 8'h00;
  end
  // --------------------------------------------------------------
  // bus side
  // --------------------------------------------------------------
  // strobe moves on the falling edge, clear of the sampling edge
  always @(negedge clk_in) begin
    if (go_in && beats_out < need) begin
      cpu_out.addr <= addr_in;
      cpu_out.addr_strobe <= 1'b1;
      cpu_out.read <= read_in;
      cpu_out.lanes <= 4'h5;
      cpu_out.burst <= burst_in;
    end else if (cpu_out.addr_strobe) begin
      cpu_out.addr_strobe <= 1'b0;
      // released bus must not keep showing the last address
      cpu_out.addr <= ~cpu_out.addr;
    end
  end
  // --------------------------------------------------------------
  // dram side
  // --------------------------------------------------------------
  always @(posedge clk_in) begin
    if (!go_in) begin
      beats_out <= 8'h00;
    end else if (ok_in) begin
      beats_out <= beats_out + 8'h01;
    end
    ras_prev <= dram_in.ras;
    if (!rstn_in) begin
      ras_rises_out <= 8'h00;
      cbr_out <= 8'h00;
    end else if (dram_in.ras && !ras_prev) begin
      ras_rises_out <= ras_rises_out + 8'h01;
      // cas already up when ras rises marks a cas-before-ras cycle
      if (dram_in.cas == CAS_ALL) begin
        cbr_out <= cbr_out + 8'h01;
      end
    end
  end
endmodule : bdra_cpu_model

// ---- tb_top.sv ----
// tb_top: directed scenarios for the dram front end
// assumes bdra_top and bdra_cpu_model; 200 MHz clock
`timescale 1ns/10ps
module tb_top;
  import bdra_pkg::*;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic go = 1'b0;
  logic [31:0] addr = 32'h0;
  logic bst = 1'b0;
  logic rd = 1'b1;
  bdra_cpu_s cpu;
  bdra_dram_s dram;
  logic rrq, mrq, ok, msb;
  logic [7:0] beats, rasn, cbr;
  int fail_count = 0;
  int total_checks = 0;
  int cyc = 0;
  always #2.5 clk = ~clk;
  bdra_top i_dut (.clk_in(clk), .rstn_in(rstn), .cpu_in(cpu), .dram_out(dram),
    .refresh_request_out(rrq), .memory_access_request_out(mrq), .cpu_ok_out(ok),
    .timer_msb_out(msb));
  bdra_cpu_model i_cpu (.clk_in(clk), .rstn_in(rstn), .go_in(go), .addr_in(addr),
    .read_in(rd), .burst_in(bst), .ok_in(ok), .dram_in(dram), .cpu_out(cpu),
    .beats_out(beats), .ras_rises_out(rasn), .cbr_out(cbr));
  // --------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task automatic results();
    $display("checks=%0d mismatches=%0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : results
  // --------------------------------------------------------------
  // scenarios
  // --------------------------------------------------------------
  task automatic t_reset();
    repeat (20) @(negedge clk);
    check(32'({dram, rrq, mrq, ok, msb}), 32'h0);
    rstn <= 1'b1;
    @(negedge clk);
    check(32'({rrq, mrq, dram.ras}), 32'h0);
  endtask : t_reset
  task automatic t_nomatch();
    logic sm = 1'b0;
    logic [7:0] r0 = rasn;
    addr <= 32'h0200_0040;
    go <= 1'b1;
    repeat (40) begin
      @(negedge clk);
      sm |= mrq;
    end
    go <= 1'b0;
    check(32'(sm), 32'h0);
    check(32'(rasn - r0), 32'h0);
  endtask : t_nomatch
  task automatic t_access(input logic [31:0] a, input logic b, input logic r);
    int t_r = 0;
    int t_m = 0;
    int t_c = 0;
    int n = 0;
    logic sm = 1'b0;
    logic [10:0] row = 11'h0;
    logic [10:0] col = 11'h0;
    logic [7:0] r0 = rasn;
    logic [7:0] need = b ? 8'h04 : 8'h01;
    // the model drives lanes 4'h5 on writes
    logic [3:0] cx = r ? CAS_ALL : 4'h5;
    addr <= a;
    bst <= b;
    rd <= r;
    go <= 1'b1;
    while (beats != need && n < 300) begin
      @(negedge clk);
      n++;
      sm |= mrq;
      if (dram.ras && t_r == 0) begin
        t_r = n;
        row = dram.addr;
      end
      if (dram.column_address_select && t_m == 0) t_m = n;
      if (dram.cas != CAS_NONE && t_c == 0) begin
        t_c = n;
        col = dram.addr;
        check(32'(dram.cas), 32'(cx));
      end
    end
    go <= 1'b0;
    check(32'(sm), 32'h1);
    check(32'(t_r > 0 && t_m > t_r && t_c > t_m), 32'h1);
    check(32'(row), 32'(a[23:13]));
    check(32'(col), 32'(a[12:2]));
    check(32'(beats), 32'(need));
    check(32'(rasn - r0), 32'h1);
    repeat (10) @(negedge clk);
  endtask : t_access
  task automatic t_refresh();
    int hi = 0;
    int rq = 0;
    int hr = 0;
    logic p = 1'b0;
    logic [7:0] c0 = cbr;
    while (!msb) @(negedge clk);
    while (msb) begin
      @(negedge clk);
      hi++;
      if (rrq && !p) rq++;
      if (rrq) hr++;
      p = rrq;
    end
    check(32'(hi), 32'd1024);
    check(32'(rq), 32'h1);
    check(32'(cbr - c0), 32'h1);
    check(32'(rrq), 32'h0);
    check(32'(hr), 32'h1);
  endtask : t_refresh
  task automatic t_arbit();
    int n = 0;
    logic [7:0] r0 = rasn;
    logic [7:0] c0 = cbr;
    while (msb) @(negedge clk);
    while (!msb) @(negedge clk);
    addr <= 32'h0100_1230;
    bst <= 1'b0;
    go <= 1'b1;
    while (rasn == r0 && n < 100) begin
      @(negedge clk);
      n++;
    end
    check(32'(cbr - c0), 32'h1);
    while (beats != 8'h01 && n < 400) begin
      @(negedge clk);
      n++;
    end
    go <= 1'b0;
    check(32'(beats), 32'h1);
    check(32'(rasn - r0), 32'h2);
  endtask : t_arbit
  // --------------------------------------------------------------
  // main sequence and hang guard
  // --------------------------------------------------------------
  initial begin
    t_reset();
    t_nomatch();
    t_access(32'h0155_5554, 1'b0, 1'b1);
    t_access(32'h0100_6008, 1'b0, 1'b0);
    t_refresh();
    t_access(32'h01ab_cd44, 1'b1, 1'b1);
    t_arbit();
    results();
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 12000) begin
      fail_count++;
      results();
    end
  end
endmodule : tb_top
